// ### hdl/sfr_map_low_part_map.vh
// addresses, reset values and field positions of the low special register map
// assumes byte-wide accesses from a core on the same clock
//
// How it works
// - reserved bits: write zero, read anything
// - fixed-zero bits always read back zero
// - fixed-one bits always read back one
// - C5h reads adc result, writes dac zero
// - i2c config at C8h, bit5 clears timer
// - i2c control D8h: status read, commands write
// - i2c data D9h: bit7 received/transmit only
// - comparator one ACh: six fields, 7:6 reserved
// - comparator two ADh: same layout as one
// - clock divider at 95h, reset zero
// - data pointer from 83h high, 82h low
// - bit addressable registers take single-bit accesses
`ifndef SFR_MAP_LOW_PART_MAP_VH
`define SFR_MAP_LOW_PART_MAP_VH

// ==========================================
// register addresses
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_CPU_CLOCK_DIVIDER 8'h95
`define ADDR_AUXILIARY_FUNCTION 8'hA2
`define ADDR_INTERRUPT_ENABLE_FIRST 8'hA8
`define ADDR_COMPARATOR_ONE 8'hAC
`define ADDR_COMPARATOR_TWO 8'hAD
`define ADDR_ADC_CONTROL 8'hC0
`define ADDR_ADC_RESULT_DAC_ZERO 8'hC5
`define ADDR_DAC_ONE 8'hC6
`define ADDR_I2C_CONFIGURATION 8'hC8
`define ADDR_I2C_CONTROL_STATUS 8'hD8
`define ADDR_I2C_DATA_BIT 8'hD9
`define ADDR_ACCUMULATOR 8'hE0
`define ADDR_INTERRUPT_ENABLE_SECOND 8'hE8
`define ADDR_MULTIPLY_HELPER 8'hF0

// ==========================================
// reset values
`define RST_ZERO 8'h00
`define RST_AUXILIARY_FUNCTION 8'h02
`define RST_ADC_CONTROL 8'h02
`define RST_I2C_CONTROL_STATUS 8'h80
`define RST_I2C_DATA_BIT 8'h80

// ==========================================
// fields and masks
`define AUX_FIXED_ZERO_MASK 8'hFB
`define CMP_STORED_MASK 8'h3C
`define CMP_OUTPUT_BIT 1
`define CMP_FLAG_BIT 0
`define ADC_DONE_FLAG_BIT 4
`define ADC_START_BIT 3
`define I2C_CONFIGURATION_STORED_MASK 8'hD3
`define I2C_CONFIGURATION_CLEAR_TIMER_BIT 5
`define I2C_CONTROL_STATUS_CLEAR_ATTENTION_BIT 7
`define I2C_CONTROL_STATUS_IDLE_BIT 6
`define I2C_CONTROL_STATUS_CLEAR_DATA_READY_BIT 5
`define I2C_CONTROL_STATUS_CLEAR_ARB_LOSS_BIT 4
`define I2C_CONTROL_STATUS_CLEAR_START_BIT 3
`define I2C_CONTROL_STATUS_CLEAR_STOP_BIT 2
`define I2C_CONTROL_STATUS_SEND_REP_START_BIT 1
`define I2C_CONTROL_STATUS_SEND_STOP_BIT 0
`define I2C_DATA_BIT_BIT 7

`endif

// ### hdl/sfr_bit_access.v
// single-bit access helper: splits a bit address and merges one bit into a byte
// assumes the caller supplies the addressed byte image combinationally
`timescale 1ns/1ns
`include "sfr_map_low_part_map.vh"
module sfr_bit_access (
	bit_addr,
	bit_wdata,
	byte_image,
	byte_readback,
	byte_addr,
	bit_addressable,
	merged_data,
	bit_value
);
	input wire [7:0] bit_addr;
	input wire bit_wdata;
	input wire [7:0] byte_image;
	input wire [7:0] byte_readback;
	output wire [7:0] byte_addr;
	output reg bit_addressable;
	output reg [7:0] merged_data;
	output wire bit_value;

	wire [2:0] bit_index;

	// ==========================================
	// bit address split, lsb of register at index 0
	assign byte_addr = {bit_addr[7:3], 3'h0};
	assign bit_index = bit_addr[2:0];
	assign bit_value = byte_readback[bit_index];

	always @* begin
		case (byte_addr)
			`ADDR_ACCUMULATOR,
			`ADDR_ADC_CONTROL,
			`ADDR_MULTIPLY_HELPER,
			`ADDR_I2C_CONFIGURATION,
			`ADDR_I2C_CONTROL_STATUS,
			`ADDR_INTERRUPT_ENABLE_FIRST,
			`ADDR_INTERRUPT_ENABLE_SECOND: bit_addressable = 1'b1;
			default: bit_addressable = 1'b0;
		endcase
	end

	always @* begin
		merged_data = byte_image;
		merged_data[bit_index] = bit_wdata;
	end
endmodule

// ### hdl/sfr_map_low_part.v
// low part of the special register map: byte and bit accesses from the core
// assumes core and peripherals share clk; status inputs need no synchroniser
`timescale 1ns/1ns
`include "sfr_map_low_part_map.vh"
module sfr_map_low_part (
	input wire clk,
	input wire rstn,
	input wire [7:0] sfr_addr,
	input wire sfr_rd,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	output reg sfr_rvalid,
	input wire [7:0] bit_addr,
	input wire bit_rd,
	input wire bit_wr,
	input wire bit_wdata,
	output reg bit_rdata,
	output reg bit_rvalid,
	input wire adc_done,
	input wire [7:0] adc_value,
	input wire comparator_one_output,
	input wire comparator_one_event,
	input wire comparator_two_output,
	input wire comparator_two_event,
	input wire received_bit_strobe,
	input wire received_bit_in,
	input wire attention_event,
	input wire data_ready_event,
	input wire arbitration_lost_event,
	input wire start_seen_event,
	input wire stop_seen_event,
	input wire master_active,
	output wire [7:0] accumulator,
	output wire [7:0] multiply_helper,
	output wire [15:0] data_pointer_pair,
	output wire [7:0] cpu_clock_divider,
	output wire [7:0] auxiliary_function,
	output wire [7:0] interrupt_enable_first,
	output wire [7:0] interrupt_enable_second,
	output wire [7:0] adc_control,
	output wire [7:0] dac_zero_value,
	output wire [7:0] dac_one_value,
	output wire [7:0] comparator_one_control,
	output wire [7:0] comparator_two_control,
	output wire [7:0] i2c_configuration,
	output reg clear_timer_interrupt,
	output reg i2c_idle,
	output reg send_repeated_start,
	output reg send_stop,
	output wire transmit_bit,
	output reg transmit_load
);

	// ==========================================
	// storage
	reg [7:0] acc_reg, mul_reg, dpl_reg, dph_reg, div_reg, aux_reg, interrupt_enable_first_reg, interrupt_enable_second_reg;
	reg [7:0] adc_control_reg, adc_result_reg, adc_result_dac_zero_value_reg, dac_one_value_reg, comparator_one_control_reg, comparator_two_control_reg, i2c_configuration_reg;
	reg rx_bit_reg, attention_reg, data_ready_reg, arb_lost_reg, start_seen_reg, stop_seen_reg, master_reg, tx_bit_reg;
	// full reset images, so the shared received bit takes only bit 7
	localparam [7:0] rst_ctrl_image = `RST_I2C_CONTROL_STATUS;
	localparam [7:0] rst_data_image = `RST_I2C_DATA_BIT;

	wire [7:0] bit_byte_addr;
	wire bit_addressable;
	wire [7:0] bit_merged;
	wire bit_value;
	wire bit_wr_ok;
	wire wr_en;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire [7:0] sel_addr;
	wire [7:0] i2c_control_status_rd;
	reg [7:0] readback;
	reg [7:0] rmw_image;

	function flag_next;
		input cur;
		input set;
		input clr;
		begin
			// hardware set wins over a clear in the same cycle
			flag_next = set | (cur & ~clr);
		end
	endfunction

	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = wr_en && (addr == target);
		end
	endfunction

	// ==========================================
	// access path: byte access wins over bit access
	assign sel_addr = (sfr_rd | sfr_wr) ? sfr_addr : bit_byte_addr;
	assign bit_wr_ok = bit_wr & bit_addressable & ~sfr_wr & ~sfr_rd;
	assign wr_en = sfr_wr | bit_wr_ok;
	assign wr_addr = sfr_wr ? sfr_addr : bit_byte_addr;
	assign wr_data = sfr_wr ? sfr_wdata : bit_merged;

	assign i2c_control_status_rd = {rx_bit_reg, attention_reg, data_ready_reg, arb_lost_reg,
		start_seen_reg, stop_seen_reg, master_reg, 1'b0};

	// nothing in this part of the map is fixed at one
	always @* begin
		case (sel_addr)
			`ADDR_DATA_POINTER_LOW: readback = dpl_reg;
			`ADDR_DATA_POINTER_HIGH: readback = dph_reg;
			`ADDR_CPU_CLOCK_DIVIDER: readback = div_reg;
			`ADDR_AUXILIARY_FUNCTION: readback = aux_reg & `AUX_FIXED_ZERO_MASK;
			`ADDR_INTERRUPT_ENABLE_FIRST: readback = interrupt_enable_first_reg;
			`ADDR_COMPARATOR_ONE: readback = comparator_one_control_reg;
			`ADDR_COMPARATOR_TWO: readback = comparator_two_control_reg;
			`ADDR_ADC_CONTROL: readback = adc_control_reg;
			`ADDR_ADC_RESULT_DAC_ZERO: readback = adc_result_reg;
			`ADDR_DAC_ONE: readback = dac_one_value_reg;
			`ADDR_I2C_CONFIGURATION: readback = i2c_configuration_reg;
			`ADDR_I2C_CONTROL_STATUS: readback = i2c_control_status_rd;
			`ADDR_I2C_DATA_BIT: readback = {rx_bit_reg, 7'h00};
			`ADDR_ACCUMULATOR: readback = acc_reg;
			`ADDR_INTERRUPT_ENABLE_SECOND: readback = interrupt_enable_second_reg;
			`ADDR_MULTIPLY_HELPER: readback = mul_reg;
			default: readback = 8'h00;
		endcase
	end

	// command register is rewritten with only the addressed bit set
	always @* begin
		if (sel_addr == `ADDR_I2C_CONTROL_STATUS) begin
			rmw_image = 8'h00;
		end else begin
			rmw_image = readback;
		end
	end

	sfr_bit_access u_bit_access (
		.bit_addr(bit_addr),
		.bit_wdata(bit_wdata),
		.byte_image(rmw_image),
		.byte_readback(readback),
		.byte_addr(bit_byte_addr),
		.bit_addressable(bit_addressable),
		.merged_data(bit_merged),
		.bit_value(bit_value)
	);

	// ==========================================
	// read answers, one cycle after the strobe
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
			sfr_rvalid <= 1'b0;
			bit_rdata <= 1'b0;
			bit_rvalid <= 1'b0;
		end else begin
			sfr_rvalid <= sfr_rd;
			bit_rvalid <= bit_rd & ~sfr_rd & ~sfr_wr;
			if (sfr_rd) begin
				sfr_rdata <= readback;
			end
			if (bit_rd & ~sfr_rd & ~sfr_wr) begin
				bit_rdata <= bit_addressable ? bit_value : 1'b0;
			end
		end
	end

	// ==========================================
	// plain read/write registers, and the write-only dac zero value at C5h
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_reg <= `RST_ZERO;
			mul_reg <= `RST_ZERO;
			dpl_reg <= `RST_ZERO;
			dph_reg <= `RST_ZERO;
			div_reg <= `RST_ZERO;
			aux_reg <= `RST_AUXILIARY_FUNCTION;
			interrupt_enable_first_reg <= `RST_ZERO;
			interrupt_enable_second_reg <= `RST_ZERO;
			adc_result_dac_zero_value_reg <= `RST_ZERO;
			dac_one_value_reg <= `RST_ZERO;
		end else begin
			if (hit(wr_addr, `ADDR_ACCUMULATOR)) begin
				acc_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_MULTIPLY_HELPER)) begin
				mul_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_DATA_POINTER_LOW)) begin
				dpl_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_DATA_POINTER_HIGH)) begin
				dph_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_CPU_CLOCK_DIVIDER)) begin
				div_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_AUXILIARY_FUNCTION)) begin
				// fixed-zero bit 2 stored as zero
				aux_reg <= wr_data & `AUX_FIXED_ZERO_MASK;
			end
			if (hit(wr_addr, `ADDR_INTERRUPT_ENABLE_FIRST)) begin
				interrupt_enable_first_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_INTERRUPT_ENABLE_SECOND)) begin
				interrupt_enable_second_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_ADC_RESULT_DAC_ZERO)) begin
				adc_result_dac_zero_value_reg <= wr_data;
			end
			if (hit(wr_addr, `ADDR_DAC_ONE)) begin
				dac_one_value_reg <= wr_data;
			end
		end
	end

	// ==========================================
	// adc control and result
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			adc_control_reg <= `RST_ADC_CONTROL;
			adc_result_reg <= `RST_ZERO;
		end else begin
			if (hit(wr_addr, `ADDR_ADC_CONTROL)) begin
				adc_control_reg <= wr_data;
			end
			if (adc_done) begin
				adc_control_reg[`ADC_START_BIT] <= 1'b0;
				adc_control_reg[`ADC_DONE_FLAG_BIT] <= 1'b1;
				adc_result_reg <= adc_value;
			end
		end
	end

	// ==========================================
	// comparators: output bit live, flag sticky
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			comparator_one_control_reg <= `RST_ZERO;
			comparator_two_control_reg <= `RST_ZERO;
		end else begin
			if (hit(wr_addr, `ADDR_COMPARATOR_ONE)) begin
				comparator_one_control_reg[5:2] <= wr_data[5:2];
			end
			if (hit(wr_addr, `ADDR_COMPARATOR_TWO)) begin
				comparator_two_control_reg[5:2] <= wr_data[5:2];
			end
			comparator_one_control_reg[7:6] <= 2'h0;
			comparator_two_control_reg[7:6] <= 2'h0;
			comparator_one_control_reg[`CMP_OUTPUT_BIT] <= comparator_one_output;
			comparator_two_control_reg[`CMP_OUTPUT_BIT] <= comparator_two_output;
			comparator_one_control_reg[`CMP_FLAG_BIT] <= comparator_one_event |
				(hit(wr_addr, `ADDR_COMPARATOR_ONE) ? wr_data[0] : comparator_one_control_reg[0]);
			comparator_two_control_reg[`CMP_FLAG_BIT] <= comparator_two_event |
				(hit(wr_addr, `ADDR_COMPARATOR_TWO) ? wr_data[0] : comparator_two_control_reg[0]);
		end
	end

	// ==========================================
	// i2c configuration and command pulses
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			i2c_configuration_reg <= `RST_ZERO;
			clear_timer_interrupt <= 1'b0;
			i2c_idle <= 1'b0;
			send_repeated_start <= 1'b0;
			send_stop <= 1'b0;
			transmit_load <= 1'b0;
			tx_bit_reg <= rst_data_image[7];
		end else begin
			clear_timer_interrupt <= 1'b0;
			i2c_idle <= 1'b0;
			send_repeated_start <= 1'b0;
			send_stop <= 1'b0;
			transmit_load <= 1'b0;
			if (hit(wr_addr, `ADDR_I2C_CONFIGURATION)) begin
				i2c_configuration_reg <= wr_data & `I2C_CONFIGURATION_STORED_MASK;
				clear_timer_interrupt <= wr_data[`I2C_CONFIGURATION_CLEAR_TIMER_BIT];
			end
			if (hit(wr_addr, `ADDR_I2C_CONTROL_STATUS)) begin
				i2c_idle <= wr_data[`I2C_CONTROL_STATUS_IDLE_BIT];
				send_repeated_start <= wr_data[`I2C_CONTROL_STATUS_SEND_REP_START_BIT];
				send_stop <= wr_data[`I2C_CONTROL_STATUS_SEND_STOP_BIT];
			end
			if (hit(wr_addr, `ADDR_I2C_DATA_BIT)) begin
				tx_bit_reg <= wr_data[`I2C_DATA_BIT_BIT];
				transmit_load <= 1'b1;
			end
		end
	end

	// ==========================================
	// i2c status flags, cleared by one-shot commands
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_bit_reg <= rst_ctrl_image[7];
			attention_reg <= 1'b0;
			data_ready_reg <= 1'b0;
			arb_lost_reg <= 1'b0;
			start_seen_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
			master_reg <= 1'b0;
		end else begin
			if (received_bit_strobe) begin
				rx_bit_reg <= received_bit_in;
			end
			master_reg <= master_active;
			attention_reg <= flag_next(attention_reg, attention_event,
				hit(wr_addr, `ADDR_I2C_CONTROL_STATUS) & wr_data[`I2C_CONTROL_STATUS_CLEAR_ATTENTION_BIT]);
			data_ready_reg <= flag_next(data_ready_reg, data_ready_event,
				hit(wr_addr, `ADDR_I2C_CONTROL_STATUS) & wr_data[`I2C_CONTROL_STATUS_CLEAR_DATA_READY_BIT]);
			arb_lost_reg <= flag_next(arb_lost_reg, arbitration_lost_event,
				hit(wr_addr, `ADDR_I2C_CONTROL_STATUS) & wr_data[`I2C_CONTROL_STATUS_CLEAR_ARB_LOSS_BIT]);
			start_seen_reg <= flag_next(start_seen_reg, start_seen_event,
				hit(wr_addr, `ADDR_I2C_CONTROL_STATUS) & wr_data[`I2C_CONTROL_STATUS_CLEAR_START_BIT]);
			stop_seen_reg <= flag_next(stop_seen_reg, stop_seen_event,
				hit(wr_addr, `ADDR_I2C_CONTROL_STATUS) & wr_data[`I2C_CONTROL_STATUS_CLEAR_STOP_BIT]);
		end
	end

	// ==========================================
	// outputs to the peripherals
	assign accumulator = acc_reg;
	assign multiply_helper = mul_reg;
	assign data_pointer_pair = {dph_reg, dpl_reg};
	assign cpu_clock_divider = div_reg;
	assign auxiliary_function = aux_reg;
	assign interrupt_enable_first = interrupt_enable_first_reg;
	assign interrupt_enable_second = interrupt_enable_second_reg;
	assign adc_control = adc_control_reg;
	assign dac_zero_value = adc_result_dac_zero_value_reg;
	assign dac_one_value = dac_one_value_reg;
	assign comparator_one_control = comparator_one_control_reg;
	assign comparator_two_control = comparator_two_control_reg;
	assign i2c_configuration = i2c_configuration_reg;
	assign transmit_bit = tx_bit_reg;
endmodule

// ### dv/sfr_map_low_part_assertions.sv
// checker for the low special register map: byte and bit accesses and their side effects
// assumes single clock clk and asynchronous active-low rstn
`timescale 1ns/1ns
module sfr_map_low_part_checker (
	input wire clk,
	input wire rstn,
	input wire [7:0] sfr_addr,
	input wire sfr_rd,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire sfr_rvalid,
	input wire [7:0] bit_addr,
	input wire bit_wr,
	input wire bit_wdata,
	input wire [7:0] accumulator,
	input wire [15:0] data_pointer_pair,
	input wire [7:0] cpu_clock_divider,
	input wire [7:0] auxiliary_function,
	input wire [7:0] dac_zero_value,
	input wire [7:0] comparator_one_control,
	input wire [7:0] comparator_two_control,
	input wire clear_timer_interrupt,
	input wire i2c_idle,
	input wire send_repeated_start,
	input wire send_stop,
	input wire transmit_bit,
	input wire transmit_load
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire bit_ok = bit_wr && !sfr_rd && !sfr_wr && bit_addr[7:3] == 5'h1C;
	// ====
	// properties
	property p_rd; sfr_rd |=> sfr_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_dac; sfr_wr && sfr_addr == 8'hC5 |=> dac_zero_value == $past(sfr_wdata); endproperty
	a_dac: assert property (p_dac) else $error("dac zero not loaded");
	property p_clr; sfr_wr && sfr_addr == 8'hC8 && sfr_wdata[5] |=> clear_timer_interrupt; endproperty
	a_clr: assert property (p_clr) else $error("timer clear missing");
	property p_idle; sfr_wr && sfr_addr == 8'hD8 && sfr_wdata[6] |=> i2c_idle; endproperty
	a_idle: assert property (p_idle) else $error("idle command missing");
	property p_rep; sfr_wr && sfr_addr == 8'hD8 |=> send_repeated_start == $past(sfr_wdata[1]); endproperty
	a_rep: assert property (p_rep) else $error("repeated start command wrong");
	property p_stop; sfr_wr && sfr_addr == 8'hD8 |=> send_stop == $past(sfr_wdata[0]); endproperty
	a_stop: assert property (p_stop) else $error("stop command wrong");
	property p_xmit; sfr_wr && sfr_addr == 8'hD9 |=> transmit_load && transmit_bit == $past(sfr_wdata[7]); endproperty
	a_xmit: assert property (p_xmit) else $error("transmit bit wrong");
	property p_div; sfr_wr && sfr_addr == 8'h95 |=> cpu_clock_divider == $past(sfr_wdata); endproperty
	a_div: assert property (p_div) else $error("divider not loaded");
	property p_dph;
		sfr_wr && sfr_addr == 8'h83 |=> data_pointer_pair == {$past(sfr_wdata), $past(data_pointer_pair[7:0])};
	endproperty
	a_dph: assert property (p_dph) else $error("pointer high wrong");
	property p_bit;
		bit_ok |=> accumulator == (($past(accumulator) & ~(8'h01 << $past(bit_addr[2:0])))
			| ({7'h00, $past(bit_wdata)} << $past(bit_addr[2:0])));
	endproperty
	a_bit: assert property (p_bit) else $error("bit write wrong");
	property p_cmp; comparator_one_control[7:6] == 2'b00 && comparator_two_control[7:6] == 2'b00; endproperty
	a_cmp: assert property (p_cmp) else $error("comparator top bits set");
	property p_aux; auxiliary_function[2] == 1'b0; endproperty
	a_aux: assert property (p_aux) else $error("aux fixed zero set");
	c_dac: cover property (sfr_wr && sfr_addr == 8'hC5);
	c_bit: cover property (bit_ok);
	c_stop: cover property (send_stop);
endmodule

bind sfr_map_low_part sfr_map_low_part_checker chk_u (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
	.sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rvalid(sfr_rvalid), .bit_addr(bit_addr),
	.bit_wr(bit_wr), .bit_wdata(bit_wdata), .accumulator(accumulator), .data_pointer_pair(data_pointer_pair),
	.cpu_clock_divider(cpu_clock_divider), .auxiliary_function(auxiliary_function),
	.dac_zero_value(dac_zero_value), .comparator_one_control(comparator_one_control),
	.comparator_two_control(comparator_two_control), .clear_timer_interrupt(clear_timer_interrupt),
	.i2c_idle(i2c_idle), .send_repeated_start(send_repeated_start), .send_stop(send_stop),
	.transmit_bit(transmit_bit), .transmit_load(transmit_load));

// ### dv/sfr_core_model.sv
// core-side model issuing byte and bit accesses to the register map
// assumes requests change at the falling edge and are taken at the next rising edge
`timescale 1ns/1ns
module sfr_core_model (
	input wire clk,
	output reg [7:0] sfr_addr,
	output reg sfr_rd,
	output reg sfr_wr,
	output reg [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire sfr_rvalid,
	output reg [7:0] bit_addr,
	output reg bit_rd,
	output reg bit_wr,
	output reg bit_wdata,
	input wire bit_rdata,
	input wire bit_rvalid
);
	initial begin
		{sfr_addr, sfr_rd, sfr_wr, sfr_wdata} = 18'h00000;
		{bit_addr, bit_rd, bit_wr, bit_wdata} = 11'h000;
	end
	// only defined addresses used for their purpose, unless a probe is commanded
	task go(input b, input r, input w, input [7:0] a, input [7:0] d);
		begin
			@(negedge clk);
			if (b) {bit_addr, bit_wdata, bit_rd, bit_wr} = {a, d[0], r, w};
			else {sfr_addr, sfr_wdata, sfr_rd, sfr_wr} = {a, d, r, w};
			@(negedge clk);
			// released address and data show the inverse, never the last value; both strobes drop to zero
			if (b) {bit_addr, bit_wdata, bit_rd, bit_wr} = {~bit_addr, ~bit_wdata, 2'b00};
			else {sfr_addr, sfr_wdata, sfr_rd, sfr_wr} = {~sfr_addr, ~sfr_wdata, 2'b00};
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		go(1'b0, 1'b0, 1'b1, a, d);
	endtask
	task bwr(input [7:0] a, input v);
		go(1'b1, 1'b0, 1'b1, a, {7'h00, v});
	endtask
	task rd(input b, input [7:0] a, output [7:0] d);
		integer n;
		begin
			go(b, 1'b1, 1'b0, a, 8'h00);
			d = 8'hXX;
			for (n = 0; n < 3 && (b ? bit_rvalid : sfr_rvalid) !== 1'b1; n = n + 1) @(negedge clk);
			if (!b && sfr_rvalid === 1'b1) d = sfr_rdata;
			if (b && bit_rvalid === 1'b1) d = {7'h00, bit_rdata};
		end
	endtask
endmodule

// ### dv/tb.sv
// self-checking bench for the low special register map
// assumes the core model drives the access ports; peripherals are driven here
`timescale 1ns/1ns
module tb;
	localparam [127:0] MAP = 128'h828395A2A8ACADC0C5C6C8D8D9E0E8F0;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg adc_done = 1'b0;
	reg [7:0] adc_value = 8'h00;
	reg [1:0] cmp_out = 2'b00;
	reg [1:0] cmp_evt = 2'b00;
	reg rx_strobe = 1'b0;
	reg rx_in = 1'b1;
	reg [4:0] ev = 5'h00;
	reg master_active = 1'b0;
	wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, accumulator, dac_zero_value;
	wire [15:0] data_pointer_pair;
	wire sfr_rd, sfr_wr, sfr_rvalid, bit_rd, bit_wr, bit_wdata, bit_rdata, bit_rvalid, transmit_bit;
	integer num_errors = 0;
	integer samples_checked = 0;
	integer cycles = 0;
	integer i, k;
	reg [7:0] a, r, w, m;
	sfr_core_model core_u (.clk(clk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .bit_addr(bit_addr), .bit_rd(bit_rd), .bit_wr(bit_wr),
		.bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .bit_rvalid(bit_rvalid));
	sfr_map_low_part dut_u (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .bit_addr(bit_addr), .bit_rd(bit_rd),
		.bit_wr(bit_wr), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .bit_rvalid(bit_rvalid), .adc_done(adc_done),
		.adc_value(adc_value), .comparator_one_output(cmp_out[0]), .comparator_one_event(cmp_evt[0]),
		.comparator_two_output(cmp_out[1]), .comparator_two_event(cmp_evt[1]), .received_bit_strobe(rx_strobe),
		.received_bit_in(rx_in), .attention_event(ev[4]), .data_ready_event(ev[3]), .arbitration_lost_event(ev[2]),
		.start_seen_event(ev[1]), .stop_seen_event(ev[0]), .master_active(master_active), .accumulator(accumulator),
		.multiply_helper(), .data_pointer_pair(data_pointer_pair), .cpu_clock_divider(), .auxiliary_function(),
		.interrupt_enable_first(), .interrupt_enable_second(), .adc_control(), .dac_zero_value(dac_zero_value),
		.dac_one_value(), .comparator_one_control(), .comparator_two_control(), .i2c_configuration(),
		.clear_timer_interrupt(), .i2c_idle(), .send_repeated_start(), .send_stop(), .transmit_bit(transmit_bit),
		.transmit_load());
	always #50 clk = ~clk;
	// ====
	// expectations
	function [7:0] rst_val(input [7:0] x);
		rst_val = (x == 8'hA2 || x == 8'hC0) ? 8'h02 : (x == 8'hD8 || x == 8'hD9) ? 8'h80 : 8'h00;
	endfunction
	// comparable bits: reserved positions may read anything
	function [7:0] cm(input [7:0] x);
		cm = (x == 8'hA2) ? 8'hFD : (x == 8'hE8) ? 8'hB7 : 8'hFF;
	endfunction
	function plain(input [7:0] x);
		plain = (x == 8'h82 || x == 8'h83 || x == 8'h95 || x == 8'hA2 || x == 8'hA8 || x == 8'hC0 || x == 8'hC6
			|| x == 8'hE0 || x == 8'hE8 || x == 8'hF0);
	endfunction
	task check(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task complete_run;
		begin
			if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			complete_run;
		end
	end
	// ====
	// scenarios
	initial begin
		r = $urandom(32'h890A362C);
		repeat (12) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		for (i = 0; i < 16; i = i + 1) begin
			core_u.rd(1'b0, MAP[127 - 8 * i -: 8], r);
			check(r, rst_val(MAP[127 - 8 * i -: 8]));
		end
		core_u.rd(1'b0, 8'h81, r);
		check(r, 8'h00);
		for (k = 0; k < 4; k = k + 1) for (i = 0; i < 16; i = i + 1) begin
			a = MAP[127 - 8 * i -: 8];
			w = $urandom & cm(a) & ((a == 8'hA2) ? 8'hFB : 8'hFF);
			if (plain(a)) begin
				core_u.wr(a, w);
				core_u.rd(1'b0, a, r);
				check(r & cm(a), w);
			end
		end
		w = $urandom;
		core_u.wr(8'h83, w);
		core_u.wr(8'h82, ~w);
		check(data_pointer_pair[15:8], w);
		check(data_pointer_pair[7:0], ~w);
		core_u.wr(8'hC5, w);
		check(dac_zero_value, w);
		core_u.wr(8'hC0, 8'h08);
		@(negedge clk) {adc_value, adc_done} = {~w, 1'b1};
		@(negedge clk) adc_done = 1'b0;
		core_u.rd(1'b0, 8'hC5, r);
		check(r, ~w);
		core_u.rd(1'b0, 8'hC0, r);
		check(r, 8'h10);
		for (i = 0; i < 2; i = i + 1) begin
			core_u.wr(8'hAC + i, 8'h3F);
			core_u.rd(1'b0, 8'hAC + i, r);
			check(r, 8'h3D);
			core_u.wr(8'hAC + i, 8'h00);
			@(negedge clk) {cmp_out[i], cmp_evt[i]} = 2'b11;
			@(negedge clk) cmp_evt = 2'b00;
			core_u.rd(1'b0, 8'hAC + i, r);
			check(r, 8'h03);
			cmp_out = 2'b00;
		end
		core_u.wr(8'hC8, 8'hF3);
		core_u.rd(1'b0, 8'hC8, r);
		check(r, 8'hD3);
		@(negedge clk) {ev, master_active} = 6'h3F;
		@(negedge clk) ev = 5'h00;
		core_u.rd(1'b0, 8'hD8, r);
		check(r, 8'hFE);
		core_u.wr(8'hD8, 8'hBC);
		core_u.wr(8'hD8, 8'h43);
		core_u.rd(1'b0, 8'hD8, r);
		check(r, 8'h82);
		@(negedge clk) {rx_in, rx_strobe} = 2'b01;
		@(negedge clk) rx_strobe = 1'b0;
		core_u.rd(1'b0, 8'hD9, r);
		check(r, 8'h00);
		core_u.wr(8'hD9, 8'h7F);
		check({7'h00, transmit_bit}, 8'h00);
		core_u.wr(8'hD9, 8'h80);
		check({7'h00, transmit_bit}, 8'h01);
		core_u.rd(1'b0, 8'hD9, r);
		check(r, 8'h00);
		m = $urandom;
		core_u.wr(8'hE0, m);
		for (k = 0; k < 24; k = k + 1) begin
			i = $urandom % 8;
			w = $urandom % 2;
			core_u.bwr({5'h1C, i[2:0]}, w[0]);
			m[i[2:0]] = w[0];
			i = $urandom % 8;
			core_u.rd(1'b1, {5'h1C, i[2:0]}, r);
			check(r, {7'h00, m[i[2:0]]});
		end
		check(accumulator, m);
		core_u.bwr(8'hAF, 1'b1);
		core_u.rd(1'b0, 8'hA8, r);
		check(r & 8'h80, 8'h80);
		core_u.rd(1'b1, 8'h90, r);
		check(r, 8'h00);
		complete_run;
	end
endmodule
